// file: rtl/anps_defines.svh
// Register offsets, field positions and reset values for the negotiation status registers
`ifndef ANPS_DEFINES_SVH
`define ANPS_DEFINES_SVH
`define NP_ABILITY_IDX      8'h05
`define EXP_STATUS_IDX      8'h06
`define INT_STATUS_IDX      8'h08
`define INT_MASK_IDX        8'h09
`define NP_ABILITY_ADDR     12'h014
`define EXP_STATUS_ADDR     12'h018
`define INT_STATUS_ADDR     12'h020
`define INT_MASK_ADDR       12'h024
`define NP_NP_BIT           15
`define NP_ACK_BIT          14
`define NP_MSG_BIT          13
`define NP_COMPLY_BIT       12
`define NP_TOGGLE_BIT       11
`define NP_CODE_MSB         10
`define NP_RESET            16'h0000
`define EXP_FAULT_BIT       4
`define EXP_PNP_BIT         3
`define EXP_LNP_BIT         2
`define EXP_PAGE_BIT        1
`define EXP_PAN_BIT         0
`define EXP_RESERVED_MSB    15
`define EXP_RESERVED_LSB    5
`define LOCAL_NP_CAPABLE    1'b1
`define INT_PAGE_BIT        0
`define INT_FAULT_BIT       1
`define INT_WIDTH           2
`endif

// file: rtl/anps_pkg.sv
// Types shared by the negotiation status register block
package anps_pkg;
	typedef logic [10:0] page_code_t;
	typedef struct packed {
		logic       valid;
		logic       next_page;
		logic       ack;
		logic       message_page_flag;
		logic       partner_comply_ack;
		logic       toggle;
		page_code_t code;
	} page_word_s;
	typedef struct packed {
		logic parallel_detect_fault;
		logic partner_extra_page_capable;
		logic partner_negotiation_capable;
	} partner_status_s;
	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_DONE = 2'b10
	} acc_state_e;
endpackage : anps_pkg

// file: rtl/anps_apb_slave.sv
// APB slave: one-wait access phase, decodes reads and writes into strobes
`timescale 1ns/1ps
`include "anps_defines.svh"
module anps_apb_slave (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// Bus
	input  wire anps_pkg::apb_req_s req,
	output anps_pkg::apb_rsp_s      rsp,
	// Register side
	output logic [11:0]        addr,
	output logic               rd_stb,
	output logic               wr_stb,
	input  wire logic [15:0]   rd_data,
	input  wire logic          addr_ok
);
	import anps_pkg::*;
	typedef struct packed {
		acc_state_e  st;
		logic [31:0] rdata;
		logic        err;
	} slave_s;
	slave_s s_q, s_d;
	always_comb begin
		s_d = s_q;
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		unique case (s_q.st)
			ACC_IDLE: begin
				// Answer one cycle into the access phase; strobes fire once
				if (req.psel && req.penable) begin
					rd_stb = !req.pwrite && addr_ok;
					wr_stb = req.pwrite && addr_ok;
					s_d.rdata = req.pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
					s_d.err = !addr_ok;
					s_d.st = ACC_DONE;
				end
			end
			ACC_DONE: begin
				s_d.st = ACC_IDLE;
			end
			default: s_d.st = ACC_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '{st: ACC_IDLE, rdata: 32'h0000_0000, err: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
	assign addr = req.paddr;
	assign rsp.pready = (s_q.st == ACC_DONE);
	assign rsp.prdata = s_q.rdata;
	assign rsp.pslverr = (s_q.st == ACC_DONE) && s_q.err;
	a_ready_one: assert property (@(posedge clk) disable iff (!rstn)
		rsp.pready |=> !rsp.pready)
		else $error("pready held more than one cycle");
endmodule : anps_apb_slave

// file: rtl/anps_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module anps_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule : anps_sync

// file: rtl/anps_status_regs.sv
// Partner next-page and negotiation expansion status registers with APB access
//
// Overview of operation
// - Message page flag set means the code field is a message code.
// - Message page flag reports page type; read-only, resets to zero.
// - Comply bit follows partner's ability to comply with the message.
// - Toggle bit is inverse of previously transmitted word's toggle value.
// - Received 11-bit code sits at bits 10:0, resets to zero.
// - Expansion bits 15:5 ignore writes and read as zero.
// - Parallel detection fault bit reports detected fault, resets zero.
// - Read-only bit shows whether partner supports next page.
// - Local next-page capability bit is fixed at one.
// - Page-received bit sets on code word, clears on register read.
// - Lowest expansion bit shows partner negotiation support, resets zero.
// - Expansion status register sits at index six.
// - Partner next-page register sits at index five.
// - Page bits update from engine only; software writes have no effect.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "anps_defines.svh"
module anps_status_regs (
	// Clock and reset
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	// APB slave
	input  wire logic [11:0]               PADDR,
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [31:0]               PWDATA,
	output logic [31:0]                    PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	// Negotiation engine, same clock
	input  wire anps_pkg::page_word_s      PAGE_WORD,
	// Partner status levels from the link side, asynchronous
	input  wire anps_pkg::partner_status_s PARTNER_STATUS,
	// Interrupt
	output logic                           IRQ
);
	import anps_pkg::*;

	typedef struct packed {
		logic [15:0]            np;
		logic                   page_rx;
		logic [`INT_WIDTH-1:0]  int_status;
		logic [`INT_WIDTH-1:0]  int_mask;
		logic                   fault_prev;
	} regs_s;

	regs_s           r_q, r_d;
	apb_req_s        req;
	apb_rsp_s        rsp;
	logic [11:0]     addr;
	logic            rd_stb;
	logic            wr_stb;
	logic [15:0]     rd_data;
	logic            addr_ok;
	partner_status_s ps;
	logic [15:0]     exp_word;

	// Decode a bus byte address into a register hit
	function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
		return a == reg_addr;
	endfunction : hit

	assign req = '{paddr: PADDR, psel: PSEL, penable: PENABLE, pwrite: PWRITE, pwdata: PWDATA};

	anps_apb_slave u_slave (
		.clk     (CLK),
		.rstn    (RSTN),
		.req     (req),
		.rsp     (rsp),
		.addr    (addr),
		.rd_stb  (rd_stb),
		.wr_stb  (wr_stb),
		.rd_data (rd_data),
		.addr_ok (addr_ok)
	);

	// Link-side levels may change at any time relative to CLK
	anps_sync #(.W(3)) u_sync (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (PARTNER_STATUS),
		.q    (ps)
	);

	always_comb begin
		exp_word = 16'h0000;
		exp_word[`EXP_FAULT_BIT] = ps.parallel_detect_fault;
		exp_word[`EXP_PNP_BIT] = ps.partner_extra_page_capable;
		exp_word[`EXP_LNP_BIT] = `LOCAL_NP_CAPABLE;
		exp_word[`EXP_PAGE_BIT] = r_q.page_rx;
		exp_word[`EXP_PAN_BIT] = ps.partner_negotiation_capable;
	end

	assign addr_ok = hit(addr, `NP_ABILITY_ADDR) || hit(addr, `EXP_STATUS_ADDR) ||
		hit(addr, `INT_STATUS_ADDR) || hit(addr, `INT_MASK_ADDR);

	always_comb begin
		rd_data = 16'h0000;
		if (hit(addr, `NP_ABILITY_ADDR)) begin
			rd_data = r_q.np;
		end else if (hit(addr, `EXP_STATUS_ADDR)) begin
			rd_data = exp_word;
		end else if (hit(addr, `INT_STATUS_ADDR)) begin
			rd_data = {14'h0000, r_q.int_status};
		end else if (hit(addr, `INT_MASK_ADDR)) begin
			rd_data = {14'h0000, r_q.int_mask};
		end
	end

	always_comb begin
		r_d = r_q;
		r_d.fault_prev = ps.parallel_detect_fault;
		// Engine alone writes page bits
		// The engine delivers toggle already inverted from our last sent word
		if (PAGE_WORD.valid) begin
			r_d.np = {PAGE_WORD.next_page, PAGE_WORD.ack, PAGE_WORD.message_page_flag,
				PAGE_WORD.partner_comply_ack, PAGE_WORD.toggle, PAGE_WORD.code};
		end
		if (rd_stb && hit(addr, `EXP_STATUS_ADDR)) begin
			r_d.page_rx = 1'b0;
		end
		if (wr_stb && hit(addr, `INT_MASK_ADDR)) begin
			r_d.int_mask = PWDATA[`INT_WIDTH-1:0];
		end
		if (wr_stb && hit(addr, `INT_STATUS_ADDR)) begin
			r_d.int_status = r_q.int_status & ~PWDATA[`INT_WIDTH-1:0];
		end
		if (PAGE_WORD.valid) begin
			r_d.page_rx = 1'b1;
			r_d.int_status[`INT_PAGE_BIT] = 1'b1;
		end
		if (ps.parallel_detect_fault && !r_q.fault_prev) begin
			r_d.int_status[`INT_FAULT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			r_q <= '{np: `NP_RESET, page_rx: 1'b0, int_status: 2'h0, int_mask: 2'h0,
				fault_prev: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign PRDATA = rsp.prdata;
	assign PREADY = rsp.pready;
	assign PSLVERR = rsp.pslverr;
	assign IRQ = |(r_q.int_status & r_q.int_mask);

	// Single-cycle events the checks below are built from
	sequence page_arrives;
		PAGE_WORD.valid;
	endsequence

	sequence np_read;
		rd_stb && hit(addr, `NP_ABILITY_ADDR);
	endsequence

	sequence exp_read;
		rd_stb && hit(addr, `EXP_STATUS_ADDR);
	endsequence

	sequence exp_write;
		wr_stb && hit(addr, `EXP_STATUS_ADDR);
	endsequence

	sequence status_read;
		rd_stb && hit(addr, `INT_STATUS_ADDR);
	endsequence

	sequence mask_write;
		wr_stb && hit(addr, `INT_MASK_ADDR);
	endsequence

	// An access that the slave has just taken, at an address that decodes to nothing
	sequence unmapped_access;
		PSEL && PENABLE && !PREADY && !addr_ok;
	endsequence

	// Pin levels only reach the register after two clean edges through the synchroniser
	sequence sync_settled;
		$past(RSTN) && $past(RSTN, 2);
	endsequence

	a_page_capture: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.np[`NP_CODE_MSB:0] == $past(PAGE_WORD.code))
		else $error("Received code not captured");
	a_msg_flag: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.np[`NP_MSG_BIT] == $past(PAGE_WORD.message_page_flag))
		else $error("Message page flag not captured");
	a_comply_ack: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.np[`NP_COMPLY_BIT] == $past(PAGE_WORD.partner_comply_ack))
		else $error("Comply bit not captured");
	a_toggle_bit: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.np[`NP_TOGGLE_BIT] == $past(PAGE_WORD.toggle))
		else $error("Toggle bit not captured");
	a_np_hold: assert property (@(posedge CLK) disable iff (!RSTN)
		!PAGE_WORD.valid |=> $stable(r_q.np))
		else $error("Next page register changed without a page");
	a_page_set: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.page_rx)
		else $error("Page received flag not set");
	a_page_cor: assert property (@(posedge CLK) disable iff (!RSTN)
		rd_stb && hit(addr, `EXP_STATUS_ADDR) && !PAGE_WORD.valid |=> !r_q.page_rx)
		else $error("Page received flag not cleared on read");
	a_exp_fixed: assert property (@(posedge CLK) disable iff (!RSTN)
		exp_word[`EXP_RESERVED_MSB:`EXP_RESERVED_LSB] == 11'h000 && exp_word[`EXP_LNP_BIT])
		else $error("Expansion fixed bits wrong");
	a_fault_evt: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(ps.parallel_detect_fault) |=> r_q.int_status[`INT_FAULT_BIT])
		else $error("Fault event not latched");
	a_irq_level: assert property (@(posedge CLK) disable iff (!RSTN)
		PAGE_WORD.valid && r_q.int_mask[`INT_PAGE_BIT] && !wr_stb |=> IRQ)
		else $error("Interrupt not raised for an enabled page event");

	// Read path: what the bus returns for each register except the interrupt mask
	a_np_read: assert property (@(posedge CLK) disable iff (!RSTN)
		np_read |=> PRDATA == {16'h0000, $past(r_q.np)})
		else $error("Next page register read back wrong");

	a_exp_read: assert property (@(posedge CLK) disable iff (!RSTN)
		exp_read |=> PRDATA == {16'h0000, $past(exp_word)})
		else $error("Expansion register read back wrong");

	a_reserved_read: assert property (@(posedge CLK) disable iff (!RSTN)
		exp_read |=> PRDATA[`EXP_RESERVED_MSB:`EXP_RESERVED_LSB] == 11'h000)
		else $error("Reserved expansion bits read nonzero");

	a_local_np: assert property (@(posedge CLK) disable iff (!RSTN)
		exp_read |=> PRDATA[`EXP_LNP_BIT] == `LOCAL_NP_CAPABLE)
		else $error("Local capability bit read wrong");

	a_status_read: assert property (@(posedge CLK) disable iff (!RSTN)
		status_read |=> PRDATA == {30'h0, $past(r_q.int_status)})
		else $error("Interrupt status read back wrong");

	a_unmapped_err: assert property (@(posedge CLK) disable iff (!RSTN)
		unmapped_access |=> PSLVERR && PRDATA == 32'h0000_0000)
		else $error("Unmapped access not refused");

	a_strobe_once: assert property (@(posedge CLK) disable iff (!RSTN)
		rd_stb |=> !rd_stb)
		else $error("Read side effect fired twice");

	// Partner levels through the synchroniser
	a_fault_sync: assert property (@(posedge CLK) disable iff (!RSTN)
		sync_settled |-> exp_word[`EXP_FAULT_BIT] ==
			$past(PARTNER_STATUS.parallel_detect_fault, 2))
		else $error("Fault bit does not follow its pin");

	a_pnp_sync: assert property (@(posedge CLK) disable iff (!RSTN)
		sync_settled |-> exp_word[`EXP_PNP_BIT] ==
			$past(PARTNER_STATUS.partner_extra_page_capable, 2))
		else $error("Partner page bit does not follow its pin");

	a_pan_sync: assert property (@(posedge CLK) disable iff (!RSTN)
		sync_settled |-> exp_word[`EXP_PAN_BIT] ==
			$past(PARTNER_STATUS.partner_negotiation_capable, 2))
		else $error("Partner negotiation bit does not follow its pin");

	// Write side effects, sticky flags and reset
	a_page_keep: assert property (@(posedge CLK) disable iff (!RSTN)
		exp_write |=> r_q.page_rx || !$past(r_q.page_rx))
		else $error("Write cleared the page received flag");

	a_page_rx_hold: assert property (@(posedge CLK) disable iff (!RSTN)
		!PAGE_WORD.valid && !(rd_stb && hit(addr, `EXP_STATUS_ADDR)) |=>
			$stable(r_q.page_rx))
		else $error("Page received flag changed without cause");

	a_mask_write: assert property (@(posedge CLK) disable iff (!RSTN)
		mask_write |=> r_q.int_mask == $past(PWDATA[`INT_WIDTH-1:0]))
		else $error("Mask write not taken");

	a_mask_keep: assert property (@(posedge CLK) disable iff (!RSTN)
		!(wr_stb && hit(addr, `INT_MASK_ADDR)) |=> $stable(r_q.int_mask))
		else $error("Mask changed without a write");

	a_page_event: assert property (@(posedge CLK) disable iff (!RSTN)
		page_arrives |=> r_q.int_status[`INT_PAGE_BIT])
		else $error("Page event not latched");

	a_status_w1c: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_stb && hit(addr, `INT_STATUS_ADDR) && PWDATA[`INT_PAGE_BIT] && !PAGE_WORD.valid
			|=> !r_q.int_status[`INT_PAGE_BIT])
		else $error("Page event not cleared by a one");

	a_status_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
		!wr_stb |=> (r_q.int_status & $past(r_q.int_status)) == $past(r_q.int_status))
		else $error("Event bit dropped without a write");

	a_reset_values: assert property (@(posedge CLK)
		!RSTN |=> r_q.np == `NP_RESET && !r_q.page_rx && r_q.int_status == 2'h0)
		else $error("Registers not at reset values");
endmodule : anps_status_regs

// file: tb/anps_link_model.sv
// Link-side model: negotiation engine pages and partner status levels
`timescale 1ns/1ps
module anps_link_model (
	// Clock
	input  wire logic                 clk,
	// Link side
	output anps_pkg::page_word_s      page_word,
	output anps_pkg::partner_status_s partner_status
);
	import anps_pkg::*;
	initial begin
		page_word = '0;
		partner_status = '0;
	end
	task automatic send_page(input logic [15:0] w);
		@(posedge clk);
		page_word <= {1'b1, w};
		@(posedge clk);
		// Released lines show the inverse, not a stale copy
		page_word <= {1'b0, ~w};
	endtask : send_page
	task automatic set_status(input logic [2:0] s);
		@(posedge clk);
		partner_status <= s;
	endtask : set_status
endmodule : anps_link_model

// file: tb/anps_status_regs_tb.sv
// Self-checking bench for the negotiation status registers
`timescale 1ns/1ps
`include "anps_defines.svh"
module anps_status_regs_tb;
	import anps_pkg::*;
	logic            clk;
	logic            rstn;
	logic [11:0]     paddr;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            irq;
	page_word_s      page_word;
	partner_status_s partner_status;
	int              err_count = 0;
	int              checked = 0;
	int              cycles = 0;
	integer          seed;
	logic [31:0]     rd;
	logic            er;
	logic [15:0]     w;
	logic [2:0]      s;

	anps_status_regs u_anps_status_regs (.CLK(clk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PAGE_WORD(page_word),
		.PARTNER_STATUS(partner_status), .IRQ(irq));
	anps_link_model u_link (.clk(clk), .page_word(page_word), .partner_status(partner_status));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Bound on the whole run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			test_done;
		end
	end

	function automatic logic [31:0] exp_ext(input logic [2:0] st, input logic prx);
		return {27'h0, st[2], st[1], `LOCAL_NP_CAPABLE, prx, st[0]};
	endfunction : exp_ext

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Deselected lines show the inverse so a stale address cannot pass
		paddr <= ~a;
		pwrite <= ~wr;
		pwdata <= ~d;
	endtask : apb

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask : rchk

	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	initial begin
		seed = 32'h67140740;
		s = 3'b000;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rchk(`NP_ABILITY_ADDR, 32'h0, 1'b0);
		rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		$display("reset values done");
		// Corner codes first, then random pages
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
			u_link.send_page(w);
			rchk(`NP_ABILITY_ADDR, {16'h0, w}, 1'b0);
			rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b1), 1'b0);
			rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		end
		$display("page capture done");
		apb(1'b1, `NP_ABILITY_ADDR, ~{16'h0, w});
		apb(1'b1, `EXP_STATUS_ADDR, 32'hffffffff);
		rchk(`NP_ABILITY_ADDR, {16'h0, w}, 1'b0);
		rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		$display("write ignore done");
		// All levels high first so the fault edge is always exercised
		for (int j = 0; j < 6; j++) begin
			s = (j == 0) ? 3'b111 : 3'($random(seed));
			u_link.set_status(s);
			repeat (3) @(posedge clk);
			rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		end
		$display("partner status done");
		apb(1'b1, `INT_STATUS_ADDR, 32'h3);
		rchk(`INT_STATUS_ADDR, 32'h0, 1'b0);
		s = 3'b000;
		u_link.set_status(s);
		repeat (3) @(posedge clk);
		s = 3'b100;
		u_link.set_status(s);
		repeat (3) @(posedge clk);
		rchk(`INT_STATUS_ADDR, 32'h2, 1'b0);
		rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		apb(1'b1, `INT_STATUS_ADDR, 32'h2);
		apb(1'b1, `INT_MASK_ADDR, 32'h1);
		u_link.send_page(16'h2001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `INT_STATUS_ADDR, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `INT_MASK_ADDR, 32'h0);
		u_link.send_page(16'h0400);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rchk(`INT_STATUS_ADDR, 32'h1, 1'b0);
		$display("interrupt done");
		// Reset in mid-run must drop the captured page and the page flag
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rchk(`NP_ABILITY_ADDR, 32'h0, 1'b0);
		rchk(`EXP_STATUS_ADDR, exp_ext(s, 1'b0), 1'b0);
		chk({31'h0, irq}, 32'h0);
		$display("mid-run reset done");
		rchk(12'h030, 32'h0, 1'b1);
		$display("unmapped done");
		test_done;
	end
endmodule : anps_status_regs_tb
